// >>> core/flash_host_pkg.sv
// constants and types for the flash erase command host controller
// Operation
// - bypass exit: 90 then 00
// - chip erase: six writes ending 10
// - block erase sixth write 30, repeatable
// - add blocks within 50 us window
// - resume with single 30 write
// - security command address outside security area
package flash_host_pkg;

	localparam int addr_w = 20;
	localparam int data_w = 16;

	localparam logic [10:0] unlock_a_word = 11'h555;
	localparam logic [10:0] unlock_b_word = 11'h2aa;
	localparam logic [11:0] unlock_a_byte = 12'haaa;
	localparam logic [11:0] unlock_b_byte = 12'h555;
	localparam logic [addr_w-1:0] security_cmd_addr = 20'h01000;

	localparam logic [7:0] code_unlock1 = 8'haa;
	localparam logic [7:0] code_unlock2 = 8'h55;
	localparam logic [7:0] code_setup = 8'h80;
	localparam logic [7:0] code_chip = 8'h10;
	localparam logic [7:0] code_block = 8'h30;
	localparam logic [7:0] code_resume = 8'h30;
	localparam logic [7:0] code_suspend = 8'hb0;
	localparam logic [7:0] code_bypass_exit1 = 8'h90;
	localparam logic [7:0] code_bypass_exit2 = 8'h00;
	localparam logic [7:0] code_security = 8'hb8;
	localparam logic [7:0] code_reset = 8'hf0;

	localparam int polling_bit_pos = 7;

	// bus timing of one write or read, in clock cycles at 100 MHz
	localparam int clk_period_ns = 10;
	localparam int wr_pulse_ns = 50;
	localparam int rd_access_ns = 80;
	localparam int wr_pulse_cycles = (wr_pulse_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int rd_access_cycles = (rd_access_ns + clk_period_ns - 1) / clk_period_ns;
	localparam logic [3:0] wr_pulse_cnt = 4'(wr_pulse_cycles);
	localparam logic [3:0] rd_access_cnt = 4'(rd_access_cycles);
	// block-select window is 50 us; the host accepts an addition only until a count of the whole window runs out
	localparam int select_window_us = 50;
	localparam int select_window_cycles = (select_window_us * 1000) / clk_period_ns;

	typedef enum logic [3:0] {
		op_none = 4'h0,
		op_chip_erase = 4'h1,
		op_block_erase = 4'h2,
		op_add_block = 4'h3,
		op_suspend = 4'h4,
		op_resume = 4'h5,
		op_bypass_exit = 4'h6,
		op_security = 4'h7,
		op_reset = 4'h8,
		op_read = 4'h9
	} host_op_e;

	typedef struct packed {
		host_op_e op;
		logic [addr_w-1:0] addr;
	} host_req_s;

	typedef struct packed {
		logic [addr_w-1:0] addr;
		logic [data_w-1:0] dq_out;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} flash_pins_s;

endpackage

// >>> core/flash_bus_cycle.sv
// one asynchronous flash bus cycle, write or read, timed in clock cycles
`timescale 1ns/10ps
module flash_bus_cycle (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic is_write_in,
	input wire logic [flash_host_pkg::addr_w-1:0] addr_in,
	input wire logic [flash_host_pkg::data_w-1:0] data_in,
	input wire logic [flash_host_pkg::data_w-1:0] dq_in,
	output flash_host_pkg::flash_pins_s pins_out,
	output logic [flash_host_pkg::data_w-1:0] rdata_out,
	output logic done_out
);

	typedef enum logic [1:0] {
		cyc_idle = 2'b00,
		cyc_active = 2'b01,
		cyc_recover = 2'b10
	} cyc_state_e;

	typedef struct packed {
		cyc_state_e st;
		logic [3:0] cnt;
		logic wr;
		flash_host_pkg::flash_pins_s pins;
		logic [flash_host_pkg::data_w-1:0] rdata;
		logic done;
	} cyc_s;

	cyc_s cur_reg;
	cyc_s cur_next;

	always_comb begin
		cur_next = cur_reg;
		cur_next.done = 1'b0;
		unique case (cur_reg.st)
			cyc_idle: begin
				if (start_in) begin
					cur_next.st = cyc_active;
					cur_next.wr = is_write_in;
					cur_next.pins.addr = addr_in;
					cur_next.pins.dq_out = data_in;
					cur_next.pins.dq_oe = is_write_in;
					cur_next.pins.ce_n = 1'b0;
					cur_next.pins.we_n = ~is_write_in;
					cur_next.pins.oe_n = is_write_in;
					cur_next.cnt = is_write_in ? flash_host_pkg::wr_pulse_cnt : flash_host_pkg::rd_access_cnt;
				end
			end
			cyc_active: begin
				if (cur_reg.cnt == 4'h0) begin
					// data and address are latched on the rising write strobe
					cur_next.st = cyc_recover;
					cur_next.pins.we_n = 1'b1;
					cur_next.pins.oe_n = 1'b1;
					if (!cur_reg.wr) begin
						cur_next.rdata = dq_in;
					end
				end else begin
					cur_next.cnt = cur_reg.cnt - 4'h1;
				end
			end
			cyc_recover: begin
				cur_next.st = cyc_idle;
				cur_next.pins.ce_n = 1'b1;
				cur_next.pins.dq_oe = 1'b0;
				cur_next.done = 1'b1;
			end
			default: begin
				cur_next.st = cyc_idle;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cur_reg <= '{st: cyc_idle, cnt: 4'h0, wr: 1'b0,
				pins: '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1},
				rdata: '0, done: 1'b0};
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign pins_out = cur_reg.pins;
	assign rdata_out = cur_reg.rdata;
	assign done_out = cur_reg.done;

endmodule

// >>> core/flash_erase_host.sv
// host-side sequencer that issues erase, suspend, resume and mode commands to the flash
`timescale 1ns/10ps
module flash_erase_host (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic byte_mode_in,
	input wire logic req_valid_in,
	input flash_host_pkg::host_req_s req_in,
	input wire logic [flash_host_pkg::data_w-1:0] dq_in,
	output logic req_ready_out,
	output logic [flash_host_pkg::addr_w-1:0] addr_out,
	output logic [flash_host_pkg::data_w-1:0] dq_out,
	output logic dq_oe_out,
	output logic ce_n_out,
	output logic oe_n_out,
	output logic we_n_out,
	output logic byte_n_out,
	output logic done_out,
	output logic [flash_host_pkg::data_w-1:0] rdata_out,
	output logic erasing_out
);

	// ------------------------------------------------------------
	// types and state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		seq_idle = 2'b00,
		seq_issue = 2'b01,
		seq_wait = 2'b10
	} seq_state_e;

	typedef struct packed {
		seq_state_e st;
		flash_host_pkg::host_op_e op;
		logic [flash_host_pkg::addr_w-1:0] target;
		logic [2:0] idx;
		logic [2:0] last;
		logic go;
		logic ready;
		logic done;
		logic [flash_host_pkg::data_w-1:0] rdata;
		logic erasing;
		logic suspended;
		logic byte_n;
		logic [15:0] win_cnt;
	} host_s;

	host_s cur_reg;
	host_s cur_next;

	flash_host_pkg::flash_pins_s pins;
	logic [flash_host_pkg::data_w-1:0] cyc_rdata;
	logic cyc_done;
	logic [flash_host_pkg::addr_w-1:0] step_addr;
	logic [7:0] step_data;
	logic step_write;

	// ------------------------------------------------------------
	// unlock addresses per bus width
	// ------------------------------------------------------------
	function automatic logic [flash_host_pkg::addr_w-1:0] unlock_addr(input logic second, input logic bm);
		logic [flash_host_pkg::addr_w-1:0] a;
		a = '0;
		// in byte mode the extra low bit is the byte address, so the pattern shifts up
		if (bm) begin
			a[11:0] = second ? flash_host_pkg::unlock_b_byte : flash_host_pkg::unlock_a_byte;
		end else begin
			a[10:0] = second ? flash_host_pkg::unlock_b_word : flash_host_pkg::unlock_a_word;
		end
		return a;
	endfunction

	// ------------------------------------------------------------
	// per-step address and data of the current command
	// ------------------------------------------------------------
	always_comb begin
		step_addr = cur_reg.target;
		step_data = flash_host_pkg::code_reset;
		step_write = 1'b1;
		unique case (cur_reg.op)
			flash_host_pkg::op_chip_erase, flash_host_pkg::op_block_erase: begin
				unique case (cur_reg.idx)
					3'h0, 3'h3: begin
						step_addr = unlock_addr(1'b0, byte_mode_in);
						step_data = flash_host_pkg::code_unlock1;
					end
					3'h1, 3'h4: begin
						step_addr = unlock_addr(1'b1, byte_mode_in);
						step_data = flash_host_pkg::code_unlock2;
					end
					3'h2: begin
						step_addr = unlock_addr(1'b0, byte_mode_in);
						step_data = flash_host_pkg::code_setup;
					end
					default: begin
						if (cur_reg.op == flash_host_pkg::op_chip_erase) begin
							step_addr = unlock_addr(1'b0, byte_mode_in);
							step_data = flash_host_pkg::code_chip;
						end else begin
							step_data = flash_host_pkg::code_block;
						end
					end
				endcase
			end
			flash_host_pkg::op_add_block: step_data = flash_host_pkg::code_block;
			flash_host_pkg::op_suspend: step_data = flash_host_pkg::code_suspend;
			flash_host_pkg::op_resume: step_data = flash_host_pkg::code_resume;
			flash_host_pkg::op_bypass_exit: begin
				step_data = (cur_reg.idx == 3'h0) ? flash_host_pkg::code_bypass_exit1 :
					flash_host_pkg::code_bypass_exit2;
			end
			flash_host_pkg::op_security: begin
				step_addr = flash_host_pkg::security_cmd_addr;
				step_data = flash_host_pkg::code_security;
			end
			flash_host_pkg::op_read: step_write = 1'b0;
			default: step_data = flash_host_pkg::code_reset;
		endcase
	end

	// ------------------------------------------------------------
	// command legality and sequencing
	// ------------------------------------------------------------
	always_comb begin
		cur_next = cur_reg;
		cur_next.go = 1'b0;
		cur_next.done = 1'b0;
		cur_next.byte_n = ~byte_mode_in;
		if (cur_reg.win_cnt != 16'h0) begin
			cur_next.win_cnt = cur_reg.win_cnt - 16'h1;
		end
		unique case (cur_reg.st)
			seq_idle: begin
				cur_next.ready = 1'b1;
				if (req_valid_in && cur_reg.ready) begin
					cur_next.ready = 1'b0;
					cur_next.op = req_in.op;
					cur_next.target = req_in.addr;
					cur_next.idx = 3'h0;
					cur_next.last = 3'h0;
					cur_next.st = seq_issue;
					unique case (req_in.op)
						flash_host_pkg::op_chip_erase, flash_host_pkg::op_block_erase: cur_next.last = 3'h5;
						flash_host_pkg::op_bypass_exit: cur_next.last = 3'h1;
						// a block joins only while the select window is still open
						flash_host_pkg::op_add_block: begin
							if (cur_reg.win_cnt == 16'h0) begin
								cur_next.st = seq_idle;
								cur_next.done = 1'b1;
							end
						end
						// the reset is ignored while suspended, so it is not sent
						flash_host_pkg::op_reset: begin
							if (cur_reg.suspended) begin
								cur_next.st = seq_idle;
								cur_next.done = 1'b1;
							end
						end
						flash_host_pkg::op_resume: begin
							if (!cur_reg.suspended) begin
								cur_next.st = seq_idle;
								cur_next.done = 1'b1;
							end
						end
						default: cur_next.last = 3'h0;
					endcase
				end
			end
			seq_issue: begin
				cur_next.go = 1'b1;
				cur_next.st = seq_wait;
			end
			seq_wait: begin
				if (cyc_done) begin
					if (cur_reg.idx == cur_reg.last) begin
						cur_next.st = seq_idle;
						cur_next.done = 1'b1;
						cur_next.rdata = cyc_rdata;
						unique case (cur_reg.op)
							flash_host_pkg::op_chip_erase: begin
								cur_next.erasing = 1'b1;
								cur_next.win_cnt = 16'h0;
							end
							flash_host_pkg::op_block_erase, flash_host_pkg::op_add_block: begin
								cur_next.erasing = 1'b1;
								cur_next.win_cnt = 16'(flash_host_pkg::select_window_cycles);
							end
							flash_host_pkg::op_suspend: begin
								cur_next.suspended = cur_reg.erasing;
								cur_next.win_cnt = 16'h0;
							end
							flash_host_pkg::op_resume: cur_next.suspended = 1'b0;
							flash_host_pkg::op_reset: cur_next.erasing = 1'b0;
							flash_host_pkg::op_read: begin
								// polling bit reads one again once the erase is over
								if (cur_reg.erasing && !cur_reg.suspended && cyc_rdata[flash_host_pkg::polling_bit_pos]) begin
									cur_next.erasing = 1'b0;
								end
							end
							default: cur_next.erasing = cur_reg.erasing;
						endcase
					end else begin
						cur_next.idx = cur_reg.idx + 3'h1;
						cur_next.st = seq_issue;
					end
				end
			end
			default: cur_next.st = seq_idle;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cur_reg <= '{st: seq_idle, op: flash_host_pkg::op_none, target: '0, idx: 3'h0, last: 3'h0,
				go: 1'b0, ready: 1'b0, done: 1'b0, rdata: '0, erasing: 1'b0, suspended: 1'b0,
				byte_n: 1'b1, win_cnt: 16'h0};
		end else begin
			cur_reg <= cur_next;
		end
	end

	// ------------------------------------------------------------
	// bus cycle engine
	// ------------------------------------------------------------
	flash_bus_cycle u_cycle (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.start_in(cur_reg.go),
		.is_write_in(step_write),
		.addr_in(step_addr),
		.data_in({8'h00, step_data}),
		.dq_in(dq_in),
		.pins_out(pins),
		.rdata_out(cyc_rdata),
		.done_out(cyc_done)
	);

	assign req_ready_out = cur_reg.ready;
	assign addr_out = pins.addr;
	assign dq_out = pins.dq_out;
	assign dq_oe_out = pins.dq_oe;
	assign ce_n_out = pins.ce_n;
	assign oe_n_out = pins.oe_n;
	assign we_n_out = pins.we_n;
	assign byte_n_out = cur_reg.byte_n;
	assign done_out = cur_reg.done;
	assign rdata_out = cur_reg.rdata;
	assign erasing_out = cur_reg.erasing;

endmodule

// >>> tb/flash_dev_model.sv
// behavioural flash device model facing the host controller
`timescale 1ns/10ps
module flash_dev_model #(
	parameter int erase_cyc = 3000
) (
	input wire logic core_clk_in,
	input wire logic [19:0] addr_in,
	input wire logic [15:0] dq_in,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic byte_n_in,
	output logic [15:0] dq_out,
	output logic busy_out,
	output logic err_out,
	output logic [7:0] n_wr_out
);
	int cnt = 0;
	int step = 0;
	logic susp = 0;
	logic chip = 0;
	logic sec = 0;
	logic tog = 0;
	logic ua;
	logic ub;
	logic [7:0] d;
	logic [7:0] seq [5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
	initial begin
		err_out = 0;
		n_wr_out = 0;
	end
	// ------------------------------
	// command decoder
	// ------------------------------
	always @(posedge we_n_in) if (!ce_n_in) begin
		d = dq_in[7:0];
		ua = byte_n_in ? addr_in[10:0] == 11'h555 : addr_in[11:0] == 12'haaa;
		ub = byte_n_in ? addr_in[10:0] == 11'h2aa : addr_in[11:0] == 12'h555;
		n_wr_out = n_wr_out + 8'h01;
		sec = 0;
		if (cnt > 0 && !susp) begin
			// chip erase takes nothing at all
			if (chip) d = d;
			else if (d == 8'hb0) susp = 1;
			else if (d == 8'h30 && step == 6) cnt = erase_cyc;
			else if (d == 8'hf0) cnt = 0;
		end else if (susp) begin
			// only a resume is heard while suspended; a reset falls through unheard
			if (d == 8'h30) begin
				susp = 0;
				step = 0;
			end
		end else if (d == 8'hb8) begin
			sec = 1;
			err_out |= addr_in < 20'h00200;
		end else if (d == 8'h90 && step == 0) step = 10;
		else if (d == 8'h00 && step == 10) step = 0;
		else if (step < 5 && d == seq[step] && (step % 3 == 1 ? ub : ua)) step++;
		else if (step == 5 && d == 8'h10 && ua) begin
			chip = 1;
			cnt = erase_cyc;
			step = 0;
		end else if (step == 5 && d == 8'h30) begin
			chip = 0;
			cnt = erase_cyc;
			step = 6;
		end else begin
			step = 0;
			err_out |= d != 8'hf0;
		end
	end
	// ------------------------------
	// erase timebase and read data
	// ------------------------------
	always @(posedge core_clk_in) begin
		tog = ~tog;
		if (cnt > 0 && !susp) begin
			cnt = cnt - 1;
			if (cnt == 0) step = 0;
		end
	end
	assign busy_out = cnt > 0;
	// a released bus toggles so a stale value is never mistaken for data
	assign dq_out = (ce_n_in || oe_n_in) ? {16{tog}} : (cnt > 0 && !susp) ? 16'h0000 :
		sec ? 16'h5a5a : 16'hffff;
endmodule

// >>> tb/flash_erase_host_checker.sv
// pin-level assertions for the flash erase host controller
`timescale 1ns/10ps
module flash_erase_host_checker (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic req_valid_in,
	input wire logic req_ready_out,
	input wire logic [19:0] addr_out,
	input wire logic [15:0] dq_out,
	input wire logic dq_oe_out,
	input wire logic ce_n_out,
	input wire logic oe_n_out,
	input wire logic we_n_out,
	input wire logic byte_n_out,
	input wire logic byte_mode_in,
	input wire logic done_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_wr_low;
		!we_n_out [*6];
	endsequence
	property p_wr_pulse;
		$fell(we_n_out) |-> s_wr_low ##1 we_n_out;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe width wrong");
	property p_wr_pins;
		!we_n_out |-> !ce_n_out && dq_oe_out && oe_n_out;
	endproperty
	a_wr_pins: assert property (p_wr_pins) else $error("write strobes inconsistent");
	property p_rd_pins;
		!oe_n_out |-> !ce_n_out && !dq_oe_out && we_n_out;
	endproperty
	a_rd_pins: assert property (p_rd_pins) else $error("read strobes inconsistent");
	property p_rd_len;
		$fell(oe_n_out) |-> !oe_n_out [*8];
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read strobe too short");
	property p_wr_hold;
		!we_n_out && !$fell(we_n_out) |-> $stable(addr_out) && $stable(dq_out);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
	property p_code_hi;
		!we_n_out |-> dq_out[15:8] == 8'h00;
	endproperty
	a_code_hi: assert property (p_code_hi) else $error("upper code byte not zero");
	property p_unlock_a;
		!we_n_out && dq_out[7:0] == 8'haa |-> byte_n_out ? addr_out[10:0] == 11'h555 : addr_out[11:0] == 12'haaa;
	endproperty
	a_unlock_a: assert property (p_unlock_a) else $error("first unlock address wrong");
	property p_unlock_b;
		!we_n_out && dq_out[7:0] == 8'h55 |-> byte_n_out ? addr_out[10:0] == 11'h2aa : addr_out[11:0] == 12'h555;
	endproperty
	a_unlock_b: assert property (p_unlock_b) else $error("second unlock address wrong");
	property p_byte_pin;
		byte_n_out == !$past(byte_mode_in);
	endproperty
	a_byte_pin: assert property (p_byte_pin) else $error("bus width pin wrong");
	property p_done_one;
		done_out |=> !done_out;
	endproperty
	a_done_one: assert property (p_done_one) else $error("done longer than one cycle");
	property p_take;
		req_valid_in && req_ready_out |=> !req_ready_out;
	endproperty
	a_take: assert property (p_take) else $error("ready stayed after take");
endmodule
bind flash_erase_host flash_erase_host_checker i_chk (.core_clk_in, .rstn_in, .req_valid_in, .req_ready_out,
	.addr_out, .dq_out, .dq_oe_out, .ce_n_out, .oe_n_out, .we_n_out, .byte_n_out, .byte_mode_in, .done_out);

// >>> tb/test_flash_erase_host.sv
// self-checking testbench for the flash erase host controller
`timescale 1ns/10ps
module test_flash_erase_host;
	typedef struct packed {logic rc; logic [15:0] rd; logic ers; logic [7:0] nw;} note_s;
	logic core_clk_in = 0;
	logic rstn_in = 0;
	logic byte_mode_in = 0;
	logic req_valid_in = 0;
	flash_host_pkg::host_req_s req_in = '0;
	logic [15:0] dq_in;
	logic [15:0] dq_out;
	logic [15:0] rdata_out;
	logic [19:0] addr_out;
	logic req_ready_out, dq_oe_out, ce_n_out, oe_n_out, we_n_out, byte_n_out, done_out, erasing_out;
	logic busy, dev_err;
	logic [7:0] n_wr;
	logic [7:0] exp_nw = 0;
	logic [31:0] seed = 32'hebde6ecb;
	int n_errors = 0;
	int samples_checked = 0;
	note_s notes [$];
	note_s nt;
	flash_erase_host i_dut (.core_clk_in, .rstn_in, .byte_mode_in, .req_valid_in, .req_in, .dq_in, .req_ready_out,
		.addr_out, .dq_out, .dq_oe_out, .ce_n_out, .oe_n_out, .we_n_out, .byte_n_out, .done_out, .rdata_out,
		.erasing_out);
	flash_dev_model i_dev (.core_clk_in, .addr_in(addr_out), .dq_in(dq_out), .ce_n_in(ce_n_out),
		.oe_n_in(oe_n_out), .we_n_in(we_n_out), .byte_n_in(byte_n_out), .dq_out(dq_in), .busy_out(busy),
		.err_out(dev_err), .n_wr_out(n_wr));
	// ------------------------------
	// helpers
	// ------------------------------
	function automatic logic [19:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[19:0];
	endfunction
	task automatic check(input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// w is the number of bus writes the request should cost
	task automatic cmd(input flash_host_pkg::host_op_e op, input logic [19:0] a, input int w, input logic ers,
		input logic [15:0] rd = 16'h0000, input logic rc = 0);
		int t;
		exp_nw = exp_nw + 8'(w);
		notes.push_back(note_s'{rc, rd, ers, exp_nw});
		@(negedge core_clk_in);
		req_in = '{op, a};
		req_valid_in = 1;
		t = 0;
		// ready is looked at between edges, so the take is the next rising edge
		while (req_ready_out !== 1'b1 && t < 100) begin
			@(negedge core_clk_in);
			t++;
		end
		@(negedge core_clk_in);
		req_valid_in = 0;
		while (done_out !== 1'b1 && t < 600) begin
			@(negedge core_clk_in);
			t++;
		end
		if (t >= 600) check(16'h0001, 16'h0000);
	endtask
	task automatic wait_idle();
		int t;
		t = 0;
		while (busy && t < 20000) begin
			@(negedge core_clk_in);
			t++;
		end
		if (t >= 20000) check(16'h0001, 16'h0000);
	endtask
	// ------------------------------
	// clock, monitor, watchdog, sequence
	// ------------------------------
	initial begin
		forever #5 core_clk_in = ~core_clk_in;
	end
	always @(negedge core_clk_in) if (done_out === 1'b1) begin
		nt = notes.pop_front();
		check({7'h00, nt.ers, nt.nw}, {7'h00, erasing_out, n_wr});
		if (nt.rc) check(nt.rd, rdata_out);
	end
	initial begin
		#600000;
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (10) @(negedge core_clk_in);
		rstn_in = 1;
		repeat (2) @(negedge core_clk_in);
		cmd(flash_host_pkg::op_chip_erase, rnd(), 6, 1);
		cmd(flash_host_pkg::op_read, rnd(), 0, 1, 16'h0000, 1);
		wait_idle();
		cmd(flash_host_pkg::op_read, rnd(), 0, 0, 16'hffff, 1);
		byte_mode_in = 1;
		cmd(flash_host_pkg::op_resume, rnd(), 0, 0);
		cmd(flash_host_pkg::op_block_erase, rnd(), 6, 1);
		cmd(flash_host_pkg::op_read, rnd(), 0, 1, 16'h0000, 1);
		cmd(flash_host_pkg::op_add_block, rnd(), 1, 1);
		cmd(flash_host_pkg::op_suspend, rnd(), 1, 1);
		cmd(flash_host_pkg::op_reset, rnd(), 0, 1);
		cmd(flash_host_pkg::op_add_block, rnd(), 0, 1);
		cmd(flash_host_pkg::op_resume, rnd(), 1, 1);
		wait_idle();
		cmd(flash_host_pkg::op_read, rnd(), 0, 0, 16'hffff, 1);
		cmd(flash_host_pkg::op_bypass_exit, rnd(), 2, 0);
		cmd(flash_host_pkg::op_security, rnd(), 1, 0);
		cmd(flash_host_pkg::op_read, rnd() & 20'h000ff, 0, 0, 16'h5a5a, 1);
		cmd(flash_host_pkg::op_reset, rnd(), 1, 0);
		cmd(flash_host_pkg::op_read, rnd(), 0, 0, 16'hffff, 1);
		check(16'h0000, {15'h0000, dev_err});
		stop_test();
	end
endmodule
